// ==== dsr_ctrl_model.sv ====
// ==========================================================
// external command controller, clock idles low between frames
// ==========================================================
module dsr_ctrl_model (
  input  wire  dbg_ser_out,
  output logic m_ser_clk = 1'b0,
  output logic m_ser_in  = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;

  // one bit: set in low phase, held 30 ns past the fall, 125 ns period
  task automatic send_bit(input logic b);
    m_ser_in = b;
    #32.5;
    m_ser_clk = 1'b1;
    #62.5;
    m_ser_clk = 1'b0;
    #30;
  endtask

  // command word, msb first; line falls back to its pull-down level
  task automatic send_cmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) send_bit(c[i]);
    m_ser_in = 1'b0;
  endtask

  // data word, msb first
  task automatic send_data(input logic [23:0] d);
    for (int i = 23; i >= 0; i--) send_bit(d[i]);
    m_ser_in = 1'b0;
  endtask

  // clock a word out, sampling late in each high phase
  task automatic read_word(output logic [23:0] d);
    d = 24'h0;
    for (int i = 0; i < 24; i++) begin
      m_ser_clk = 1'b1;
      #62.5;
      d = {d[22:0], dbg_ser_out};
      m_ser_clk = 1'b0;
      #62.5;
    end
  endtask
endmodule

// ==== dsr_debug_port.v ====
`include "dsr_defs.vh"

// Notes on behaviour
// - serial input taken only in debug mode
// - command and data words arrive msb first
// - input bits captured on serial clock fall
// - output bits launched on serial clock rise
// - outside debug, shared pins show status
// - output word comes from selected register
// - outgoing word shifted msb first
// - low pulse on entering debug mode
// - low pulse when read data ready
// - low pulse requesting write data
// - low pulse after write data stored
// - input/status0 pin floats while turning round
// - clock/status1 pin floats while turning round
// - debug request halts core into debug
module dsr_debug_port #(
  parameter CMD_W  = `DSR_CMD_W,
  parameter DATA_W = `DSR_DATA_W
) (
  input  wire              clk,
  input  wire              rst_b,
  // shared serial input / status 0 pin
  input  wire              dbg_ser_in,
  output reg               op_status_0,
  output reg               op_status_0_oe,
  // shared serial clock / status 1 pin
  input  wire              dbg_ser_clk,
  output reg               op_status_1,
  output reg               op_status_1_oe,
  // serial output with acknowledge pulses
  output reg               dbg_ser_out,
  // debug request pin, active low
  input  wire              debug_request_n,
  // core side
  input  wire              core_in_debug,
  input  wire [1:0]        core_status,
  output reg               core_halt_req,
  output reg  [CMD_W-1:0]  dbg_cmd,
  output reg               dbg_cmd_strobe,
  input  wire [DATA_W-1:0] dbg_rd_data,
  input  wire              dbg_rd_valid,
  output reg  [DATA_W-1:0] dbg_wr_data,
  output reg               dbg_wr_strobe,
  input  wire              dbg_wr_done
);

  // ==========================================================
  // constants
  // ==========================================================
  localparam [3:0] ST_RUN    = 4'h0;  // core running, port idle
  localparam [3:0] ST_ACK    = 4'h1;  // low acknowledge pulse
  localparam [3:0] ST_HOLD   = 4'h2;  // wait for request release
  localparam [3:0] ST_CMD    = 4'h3;  // shift in a command
  localparam [3:0] ST_DEC    = 4'h4;  // decode the command
  localparam [3:0] ST_RDWAIT = 4'h5;  // wait for read data
  localparam [3:0] ST_RDSH   = 4'h6;  // shift read data out
  localparam [3:0] ST_WRSH   = 4'h7;  // shift write data in
  localparam [3:0] ST_WRGO   = 4'h8;  // hand write data to core
  localparam [3:0] ST_WRWAIT = 4'h9;  // wait for write done

  localparam integer            ACK_I    = `DSR_ACK_CYC;   // pulse width in cycles
  localparam integer            TURN_I   = `DSR_TURN_CYC;  // float gap in cycles
  localparam [`DSR_TIMER_W-1:0] ACK_CYC  = ACK_I[`DSR_TIMER_W-1:0];
  localparam [`DSR_TIMER_W-1:0] TURN_CYC = TURN_I[`DSR_TIMER_W-1:0];
  localparam [`DSR_CNT_W-1:0]   CMD_LAST = CMD_W[`DSR_CNT_W-1:0] - {{(`DSR_CNT_W-1){1'b0}}, 1'b1};
  localparam [`DSR_CNT_W-1:0]   DAT_LAST = DATA_W[`DSR_CNT_W-1:0] - {{(`DSR_CNT_W-1){1'b0}}, 1'b1};
  localparam [`DSR_CNT_W-1:0]   DAT_DONE = DATA_W[`DSR_CNT_W-1:0];

  // ==========================================================
  // declarations
  // ==========================================================
  wire                    ck_s;         // synchronised serial clock
  wire                    din_s;        // synchronised serial input
  wire                    req_n_s;      // synchronised request
  reg                     ck_prev_reg;  // serial clock one cycle ago
  reg                     req_prev_reg; // request one cycle ago
  wire                    ck_fall;      // falling edge seen
  wire                    ck_rise;      // rising edge seen
  wire                    req_fall;     // request newly asserted
  reg  [3:0]              state_reg;    // port controller state
  reg  [3:0]              ret_reg;      // state after the pulse
  reg  [`DSR_TIMER_W-1:0] ack_cnt_reg;  // pulse length timer
  reg  [`DSR_CNT_W-1:0]   bit_cnt_reg;  // bits moved so far
  wire                    in_shift;     // shift input register
  wire                    out_shift;    // shift output register
  wire                    out_load;     // load output register
  wire [DATA_W-1:0]       in_q;         // received bits
  wire [DATA_W-1:0]       out_q;        // bits still to send
  reg                     pin_dbg_reg;  // role the pins are in
  reg  [`DSR_TIMER_W-1:0] turn_cnt_reg; // turnaround timer

  // ==========================================================
  // synchronisers and edge detect
  // ==========================================================
  // serial clock idles low through the pull-down
  dsr_sync2 #(.RST_VAL(1'b0)) u_sync_ck (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (dbg_ser_clk),
    .sync_out (ck_s)
  );

  dsr_sync2 #(.RST_VAL(1'b0)) u_sync_din (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (dbg_ser_in),
    .sync_out (din_s)
  );

  // request idles high through the pull-up
  dsr_sync2 #(.RST_VAL(1'b1)) u_sync_req (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (debug_request_n),
    .sync_out (req_n_s)
  );

  // previous values for edge finding
  always @(posedge clk) begin
    if (!rst_b) begin
      ck_prev_reg  <= 1'b0;
      req_prev_reg <= 1'b1;
    end else begin
      ck_prev_reg  <= ck_s;
      req_prev_reg <= req_n_s;
    end
  end

  // the clock limit of clk/8 leaves each level several samples
  assign ck_fall  = ck_prev_reg & ~ck_s;
  assign ck_rise  = ~ck_prev_reg & ck_s;
  assign req_fall = req_prev_reg & ~req_n_s;

  // ==========================================================
  // shift registers
  // ==========================================================
  // bits enter only while a word is expected in debug mode
  assign in_shift  = ck_fall & ((state_reg == ST_CMD) |
                                (state_reg == ST_WRSH));
  assign out_shift = ck_rise & (state_reg == ST_RDSH) &
                     (bit_cnt_reg != DAT_DONE);
  assign out_load  = (state_reg == ST_RDWAIT) & dbg_rd_valid;

  // first bit received ends up at the top
  dsr_shreg #(.WIDTH(DATA_W)) u_in_sh (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (1'b0),
    .load_val ({DATA_W{1'b0}}),
    .shift_en (in_shift),
    .ser_in   (din_s),
    .q        (in_q)
  );

  // top bit is always the next to send
  dsr_shreg #(.WIDTH(DATA_W)) u_out_sh (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (out_load),
    .load_val (dbg_rd_data),
    .shift_en (out_shift),
    .ser_in   (1'b0),
    .q        (out_q)
  );

  // ==========================================================
  // port controller
  // ==========================================================
  // sequences commands, data and acknowledge pulses
  always @(posedge clk) begin
    if (!rst_b) begin
      state_reg      <= ST_RUN;
      ret_reg        <= ST_RUN;
      ack_cnt_reg    <= {`DSR_TIMER_W{1'b0}};
      bit_cnt_reg    <= {`DSR_CNT_W{1'b0}};
      dbg_ser_out    <= `DSR_RST_SER_OUT;
      core_halt_req  <= 1'b0;
      dbg_cmd        <= {CMD_W{1'b0}};
      dbg_cmd_strobe <= 1'b0;
      dbg_wr_data    <= {DATA_W{1'b0}};
      dbg_wr_strobe  <= 1'b0;
    end else begin
      // strobes last one cycle
      dbg_cmd_strobe <= 1'b0;
      dbg_wr_strobe  <= 1'b0;
      // halt request held from request until the core stops
      if (core_in_debug) begin
        core_halt_req <= 1'b0;
      end else if (!req_n_s) begin
        core_halt_req <= 1'b1;
      end
      if (!core_in_debug) begin
        // leaving debug mode drops any transfer
        state_reg   <= ST_RUN;
        dbg_ser_out <= `DSR_RST_SER_OUT;
        bit_cnt_reg <= {`DSR_CNT_W{1'b0}};
      end else if ((state_reg == ST_RUN) ||
                   (req_fall && state_reg != ST_ACK && state_reg != ST_HOLD)) begin
        // debug entry, or a request in debug that resets the controller:
        // acknowledge, drop any half word, wait for the request to go
        state_reg   <= ST_ACK;
        ret_reg     <= ST_HOLD;
        ack_cnt_reg <= ACK_CYC;
        dbg_ser_out <= 1'b0;
        bit_cnt_reg <= {`DSR_CNT_W{1'b0}};
      end else begin
        case (state_reg)
          ST_ACK: begin
            // hold the line low for the pulse width
            if (ack_cnt_reg == {{(`DSR_TIMER_W-1){1'b0}}, 1'b1}) begin
              dbg_ser_out <= 1'b1;
              state_reg   <= ret_reg;
              bit_cnt_reg <= {`DSR_CNT_W{1'b0}};
            end else begin
              ack_cnt_reg <= ack_cnt_reg - {{(`DSR_TIMER_W-1){1'b0}}, 1'b1};
            end
          end
          ST_HOLD: begin
            // no command bits until the request is released
            if (req_n_s) begin
              state_reg <= ST_CMD;
            end
          end
          ST_CMD: begin
            // count command bits on falling edges
            if (ck_fall) begin
              if (bit_cnt_reg == CMD_LAST) begin
                state_reg <= ST_DEC;
              end
              bit_cnt_reg <= bit_cnt_reg + {{(`DSR_CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_DEC: begin
            // latch the command, it selects the register
            dbg_cmd        <= in_q[CMD_W-1:0];
            dbg_cmd_strobe <= 1'b1;
            bit_cnt_reg    <= {`DSR_CNT_W{1'b0}};
            if (in_q[`DSR_CMD_RD_BIT]) begin
              state_reg <= ST_RDWAIT;
            end else begin
              // ask the controller for the write word
              state_reg   <= ST_ACK;
              ret_reg     <= ST_WRSH;
              ack_cnt_reg <= ACK_CYC;
              dbg_ser_out <= 1'b0;
            end
          end
          ST_RDWAIT: begin
            // data loaded: tell the controller to clock it out
            if (dbg_rd_valid) begin
              state_reg   <= ST_ACK;
              ret_reg     <= ST_RDSH;
              ack_cnt_reg <= ACK_CYC;
              dbg_ser_out <= 1'b0;
            end
          end
          ST_RDSH: begin
            // launch on rise; after the last bit, end on a fall
            if (out_shift) begin
              dbg_ser_out <= out_q[DATA_W-1];
              bit_cnt_reg <= bit_cnt_reg + {{(`DSR_CNT_W-1){1'b0}}, 1'b1};
            end else if (ck_fall && bit_cnt_reg == DAT_DONE) begin
              dbg_ser_out <= 1'b1;
              state_reg   <= ST_CMD;
              bit_cnt_reg <= {`DSR_CNT_W{1'b0}};
            end
          end
          ST_WRSH: begin
            // count write data bits on falling edges
            if (ck_fall) begin
              if (bit_cnt_reg == DAT_LAST) begin
                state_reg <= ST_WRGO;
              end
              bit_cnt_reg <= bit_cnt_reg + {{(`DSR_CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_WRGO: begin
            // hand the assembled word to the core
            dbg_wr_data   <= in_q;
            dbg_wr_strobe <= 1'b1;
            state_reg     <= ST_WRWAIT;
          end
          ST_WRWAIT: begin
            // word stored: confirm to the controller
            if (dbg_wr_done) begin
              state_reg   <= ST_ACK;
              ret_reg     <= ST_CMD;
              ack_cnt_reg <= ACK_CYC;
              dbg_ser_out <= 1'b0;
            end
          end
          default: begin
            state_reg   <= ST_RUN;
            dbg_ser_out <= `DSR_RST_SER_OUT;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // shared status pins
  // ==========================================================
  // outputs show status outside debug; float for a gap on each change
  always @(posedge clk) begin
    if (!rst_b) begin
      pin_dbg_reg    <= 1'b0;
      turn_cnt_reg   <= {`DSR_TIMER_W{1'b0}};
      op_status_0    <= 1'b0;
      op_status_1    <= 1'b0;
      op_status_0_oe <= `DSR_RST_STAT_OE;
      op_status_1_oe <= `DSR_RST_STAT_OE;
    end else begin
      // status values follow the core every cycle
      op_status_0 <= core_status[0];
      op_status_1 <= core_status[1];
      if (core_in_debug != pin_dbg_reg) begin
        // role change: release both pins first
        pin_dbg_reg    <= core_in_debug;
        turn_cnt_reg   <= TURN_CYC;
        op_status_0_oe <= 1'b0;
        op_status_1_oe <= 1'b0;
      end else if (turn_cnt_reg != {`DSR_TIMER_W{1'b0}}) begin
        // gap over: drive only when not in debug mode
        if (turn_cnt_reg == {{(`DSR_TIMER_W-1){1'b0}}, 1'b1}) begin
          op_status_0_oe <= ~pin_dbg_reg;
          op_status_1_oe <= ~pin_dbg_reg;
        end
        turn_cnt_reg <= turn_cnt_reg - {{(`DSR_TIMER_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ==== dsr_debug_port_props.sv ====
`include "dsr_defs.vh"

// ==========================================================
// port checker for the debug serial port
// ==========================================================
module dsr_props #(
  parameter CMD_W  = `DSR_CMD_W,
  parameter DATA_W = `DSR_DATA_W
) (
  input wire              clk,
  input wire              rst_b,
  input wire              dbg_ser_in,
  input wire              op_status_0,
  input wire              op_status_0_oe,
  input wire              dbg_ser_clk,
  input wire              op_status_1,
  input wire              op_status_1_oe,
  input wire              dbg_ser_out,
  input wire              debug_request_n,
  input wire              core_in_debug,
  input wire [1:0]        core_status,
  input wire              core_halt_req,
  input wire [CMD_W-1:0]  dbg_cmd,
  input wire              dbg_cmd_strobe,
  input wire [DATA_W-1:0] dbg_rd_data,
  input wire              dbg_rd_valid,
  input wire [DATA_W-1:0] dbg_wr_data,
  input wire              dbg_wr_strobe,
  input wire              dbg_wr_done
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ========================================================
  // acknowledge pulses: four cycles low, then high again
  // ========================================================
  a_entry_ack: assert property ($rose(core_in_debug)
    |=> (!dbg_ser_out)[*4] ##1 dbg_ser_out) else $error("entry pulse wrong");
  a_read_ack: assert property ($rose(dbg_rd_valid) && core_in_debug
    |=> (!dbg_ser_out)[*4] ##1 dbg_ser_out) else $error("read pulse wrong");
  a_write_ack: assert property ($rose(dbg_wr_done) && core_in_debug
    |=> (!dbg_ser_out)[*4] ##1 dbg_ser_out) else $error("write pulse wrong");

  // ========================================================
  // shared pins float two cycles when the mode changes
  // ========================================================
  a_pin0_turn: assert property ($changed(core_in_debug) |=> (!op_status_0_oe)[*2]
    ##1 (op_status_0_oe == !$past(core_in_debug, 3))) else $error("pin 0 turnaround wrong");
  a_pin1_turn: assert property ($changed(core_in_debug) |=> (!op_status_1_oe)[*2]
    ##1 (op_status_1_oe == !$past(core_in_debug, 3))) else $error("pin 1 turnaround wrong");

  // ========================================================
  // status, halt request and idle behaviour
  // ========================================================
  a_status_copy: assert property (op_status_0_oe && op_status_1_oe && $past(rst_b)
    |-> {op_status_1, op_status_0} == $past(core_status)) else $error("status pins wrong");
  a_halt_req: assert property ($fell(debug_request_n) && !core_in_debug
    |-> ##[1:6] core_halt_req) else $error("halt request missing");
  a_idle_ignore: assert property (!core_in_debug && !$past(core_in_debug)
    |-> !dbg_cmd_strobe && !dbg_wr_strobe) else $error("word taken outside debug");
  a_idle_high: assert property (!core_in_debug && !$past(core_in_debug)
    && !$past(core_in_debug, 2) |-> dbg_ser_out) else $error("serial out not idle high");
  a_cmd_pulse: assert property (dbg_cmd_strobe |=> !dbg_cmd_strobe)
    else $error("command strobe too long");
  a_write_req: assert property (dbg_cmd_strobe && !dbg_cmd[`DSR_CMD_RD_BIT]
    |-> (!dbg_ser_out)[*4] ##1 dbg_ser_out) else $error("write request pulse wrong");
endmodule

bind dsr_debug_port dsr_props #(.CMD_W(CMD_W), .DATA_W(DATA_W)) u_dsr_props (
  .clk(clk), .rst_b(rst_b), .dbg_ser_in(dbg_ser_in), .op_status_0(op_status_0),
  .op_status_0_oe(op_status_0_oe), .dbg_ser_clk(dbg_ser_clk), .op_status_1(op_status_1),
  .op_status_1_oe(op_status_1_oe), .dbg_ser_out(dbg_ser_out),
  .debug_request_n(debug_request_n), .core_in_debug(core_in_debug),
  .core_status(core_status), .core_halt_req(core_halt_req), .dbg_cmd(dbg_cmd),
  .dbg_cmd_strobe(dbg_cmd_strobe), .dbg_rd_data(dbg_rd_data), .dbg_rd_valid(dbg_rd_valid),
  .dbg_wr_data(dbg_wr_data), .dbg_wr_strobe(dbg_wr_strobe), .dbg_wr_done(dbg_wr_done));

// ==== dsr_defs.vh ====
`ifndef DSR_DEFS_VH
`define DSR_DEFS_VH

// ==========================================================
// clock rate
// ==========================================================
`define DSR_CLK_MHZ      100

// ==========================================================
// word layout
// ==========================================================
`define DSR_CMD_W        8
`define DSR_DATA_W       24
`define DSR_CNT_W        5
// command bit that selects a read (1) or a write (0)
`define DSR_CMD_RD_BIT   7
// command field that selects the target register
`define DSR_CMD_SEL_MSB  6
`define DSR_CMD_SEL_LSB  0

// ==========================================================
// timing
// ==========================================================
// width of one low acknowledge pulse, least time
`define DSR_ACK_NS       40
`define DSR_ACK_CYC      ((`DSR_ACK_NS * `DSR_CLK_MHZ + 999) / 1000)
// high impedance gap while a shared pin turns round, least time
`define DSR_TURN_NS      20
`define DSR_TURN_CYC     ((`DSR_TURN_NS * `DSR_CLK_MHZ + 999) / 1000)
`define DSR_TIMER_W      4

// ==========================================================
// reset values
// ==========================================================
`define DSR_RST_SER_OUT  1'b1
`define DSR_RST_STATUS   2'h0
`define DSR_RST_STAT_OE  1'b1

`endif

// ==== dsr_shreg.v ====
// ==========================================================
// msb-first shift register with parallel load
// ==========================================================
module dsr_shreg #(
  parameter WIDTH = 24
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             load,
  input  wire [WIDTH-1:0] load_val,
  input  wire             shift_en,
  input  wire             ser_in,
  output reg  [WIDTH-1:0] q
);

  // load wins over shift; shifting moves bits toward the msb
  always @(posedge clk) begin
    if (!rst_b) begin
      q <= {WIDTH{1'b0}};
    end else if (load) begin
      q <= load_val;
    end else if (shift_en) begin
      q <= {q[WIDTH-2:0], ser_in};
    end
  end

endmodule

// ==== dsr_sync2.v ====
// ==========================================================
// two flop synchroniser for one level from outside the clock
// ==========================================================
module dsr_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_b,
  input  wire async_in,
  output reg  sync_out
);

  reg meta_reg;  // first stage, read only by the second stage

  // two stages in series, reset to the idle level
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== tb.sv ====
// ==========================================================
// testbench: the bench plays the core, the model the controller
// ==========================================================
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk             = 1'b0;
  logic        rst_b           = 1'b0;
  logic        debug_request_n = 1'b1;
  logic        core_in_debug   = 1'b0;
  logic [1:0]  core_status     = 2'h0;
  logic [23:0] dbg_rd_data     = 24'ha5c3f1;
  logic        dbg_rd_valid    = 1'b0;
  logic        dbg_wr_done     = 1'b0;
  logic        m_drv           = 1'b0; // controller drives the shared pins
  logic [7:0]  cmd_seen        = 8'h0;
  logic [23:0] wr_seen         = 24'h0;
  int          cmd_cnt         = 0;
  int          err_count       = 0;
  int          total_checks    = 0;
  int          cyc             = 0;
  wire         op_status_0, op_status_0_oe, op_status_1, op_status_1_oe;
  wire         dbg_ser_out, core_halt_req, dbg_cmd_strobe, dbg_wr_strobe;
  wire [7:0]   dbg_cmd;
  wire [23:0]  dbg_wr_data;
  wire         m_ser_in, m_ser_clk;
  // pin levels: device, else controller, else pull-down
  wire         pin_in  = op_status_0_oe ? op_status_0 : (m_drv ? m_ser_in : 1'b0);
  wire         pin_clk = op_status_1_oe ? op_status_1 : (m_drv ? m_ser_clk : 1'b0);

  initial begin
    forever #5 clk = ~clk;
  end

  dsr_debug_port u_dsr_debug_port (
    .clk(clk), .rst_b(rst_b), .dbg_ser_in(pin_in), .op_status_0(op_status_0),
    .op_status_0_oe(op_status_0_oe), .dbg_ser_clk(pin_clk), .op_status_1(op_status_1),
    .op_status_1_oe(op_status_1_oe), .dbg_ser_out(dbg_ser_out),
    .debug_request_n(debug_request_n), .core_in_debug(core_in_debug),
    .core_status(core_status), .core_halt_req(core_halt_req), .dbg_cmd(dbg_cmd),
    .dbg_cmd_strobe(dbg_cmd_strobe), .dbg_rd_data(dbg_rd_data), .dbg_rd_valid(dbg_rd_valid),
    .dbg_wr_data(dbg_wr_data), .dbg_wr_strobe(dbg_wr_strobe), .dbg_wr_done(dbg_wr_done));

  dsr_ctrl_model u_dsr_ctrl_model (
    .dbg_ser_out(dbg_ser_out), .m_ser_clk(m_ser_clk), .m_ser_in(m_ser_in));

  // ========================================================
  // core side: capture words, answer reads and writes
  // ========================================================
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dbg_cmd_strobe === 1'b1) cmd_seen <= dbg_cmd;
    if (dbg_cmd_strobe === 1'b1) cmd_cnt <= cmd_cnt + 1;
    if (dbg_wr_strobe === 1'b1) wr_seen <= dbg_wr_data;
  end
  always @(negedge clk) begin
    dbg_rd_valid <= (dbg_cmd_strobe === 1'b1) && (dbg_cmd[7] === 1'b1);
    dbg_wr_done <= (dbg_wr_strobe === 1'b1);
  end
  // hang guard
  always @(posedge clk) begin
    if (cyc == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits for a low pulse and returns its width in cycles
  task automatic wait_ack(output int w);
    int i;
    i = 0;
    w = 0;
    while (dbg_ser_out !== 1'b0 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    while (dbg_ser_out === 1'b0 && w < 100) begin
      @(negedge clk);
      w++;
    end
  endtask

  // ========================================================
  // scenarios
  // ========================================================
  // status codes on the pins; their toggling must not be taken as bits
  task automatic t_status();
    for (int i = 0; i < 12; i++) begin
      core_status = i[1:0];
      repeat (3) @(negedge clk);
      chk({op_status_1_oe, op_status_0_oe, op_status_1, op_status_0}, {2'b11, i[1:0]});
    end
    chk(cmd_cnt, 0);
  endtask

  // request, halt, entry pulse, pins float, request released
  task automatic t_enter();
    int w;
    int i;
    i = 0;
    debug_request_n = 1'b0;
    while (core_halt_req !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    chk(core_halt_req, 1'b1);
    core_in_debug = 1'b1;
    fork
      wait_ack(w);
      begin
        repeat (2) @(negedge clk);
        chk({op_status_1_oe, op_status_0_oe}, 2'b00);
      end
    join
    chk(w, 4);
    debug_request_n = 1'b1;
    m_drv = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  // read command, wait for the pulse, then clock the word out
  task automatic t_read();
    int w;
    logic [23:0] d;
    u_dsr_ctrl_model.send_cmd(8'h85);
    wait_ack(w);
    chk(w, 4);
    chk(cmd_seen, 8'h85);
    u_dsr_ctrl_model.read_word(d);
    chk(d, 24'ha5c3f1);
  endtask

  // stray bits, then a request in debug: pulse, half word dropped
  task automatic t_resync();
    int w;
    repeat (3) u_dsr_ctrl_model.send_bit(1'b1);
    @(negedge clk);
    debug_request_n = 1'b0;
    wait_ack(w);
    chk(w, 4);
    debug_request_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(dbg_ser_out, 1'b1);
  endtask

  // write command, data after the request pulse, stored pulse
  task automatic t_write();
    int w;
    u_dsr_ctrl_model.send_cmd(8'h12);
    wait_ack(w);
    chk(w, 4);
    chk(cmd_seen, 8'h12);
    u_dsr_ctrl_model.send_data(24'h3c5a96);
    wait_ack(w);
    chk(w, 4);
    chk(wr_seen, 24'h3c5a96);
  endtask

  // leaving debug: two cycles floating, then status again
  task automatic t_exit();
    m_drv = 1'b0;
    core_in_debug = 1'b0;
    core_status = 2'h2;
    repeat (2) @(negedge clk);
    chk({op_status_1_oe, op_status_0_oe}, 2'b00);
    repeat (2) @(negedge clk);
    chk({op_status_1_oe, op_status_0_oe, op_status_1, op_status_0, dbg_ser_out}, 5'h1d);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    chk({dbg_ser_out, op_status_1_oe, op_status_0_oe, op_status_1, op_status_0}, 5'h1c);
    chk({core_halt_req, dbg_cmd_strobe, dbg_wr_strobe}, 3'h0);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_status();
    t_enter();
    t_read();
    t_resync();
    t_write();
    t_exit();
    tally_and_finish();
  end
endmodule
